// [hw/bad_decoder.sv]
// Top of the BIOS and I/O address decoder with its configuration registers
`timescale 1ns/1ps
module bad_decoder (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        cycle_valid,
	input  wire logic        cycle_io,
	input  wire logic        cycle_write,
	input  wire logic [31:2] latched_addr,
	input  wire logic [3:0]  byte_en_n,
	input  wire logic [7:0]  wdata,
	output logic             bios_chip_select_n,
	output logic [3:0]       io_target,
	output logic             io_write_only,
	output logic             io_claim,
	output logic [7:0]       rdata,
	output logic             floppy_dma_enable,
	output logic [7:0]       rtc_index
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] enable_a;
		logic [7:0] enable_b;
		logic [7:0] sg_base;
		logic [7:0] cfg_index;
		logic       fdc_bit;
		logic [7:0] rtc_copy;
		logic       cs_n;
		logic [3:0] target;
		logic       wo;
		logic       claim;
		logic [7:0] rdata;
	} bad_state_t;

	bad_state_t st_reg;
	bad_state_t st_next;

	logic [1:0]           lane;
	logic [15:0]          port;
	logic                 bios_hit;
	bad_pkg::bad_target_t tgt;
	logic                 any_lane;

	function automatic logic [1:0] low_lane(input logic [3:0] be_n);
		logic [1:0] l;
		l = 2'h0;
		if (!be_n[0]) l = 2'h0;
		else if (!be_n[1]) l = 2'h1;
		else if (!be_n[2]) l = 2'h2;
		else l = 2'h3;
		return l;
	endfunction

	function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [1:0] l);
		return w[8*l +: 8];
	endfunction

	// ****************************************
	// Decoders
	// ****************************************
	always_comb begin
		lane     = low_lane(byte_en_n);
		any_lane = (byte_en_n != 4'hf);
		port     = {latched_addr[15:2], lane};
	end

	bad_bios_decode u_bios (
		.addr     (latched_addr),
		.enable_a (st_reg.enable_a),
		.enable_b (st_reg.enable_b),
		.hit      (bios_hit)
	);

	bad_io_decode u_io (
		.port    (port),
		.sg_base (st_reg.sg_base),
		.target  (tgt)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_next = st_reg;
		// Select held for the whole cycle, dropped between cycles
		st_next.cs_n  = !(cycle_valid && !cycle_io && any_lane && bios_hit);
		st_next.target = 4'(bad_pkg::TGT_NONE);
		st_next.wo     = 1'b0;
		st_next.claim  = 1'b0;
		if (cycle_valid && cycle_io && any_lane) begin
			st_next.target = 4'(tgt);
			st_next.wo = (tgt == bad_pkg::TGT_TIMER && port[1:0] == 2'h3) ||
				(tgt == bad_pkg::TGT_NMI_MASK) ||
				(tgt == bad_pkg::TGT_DMA1 && port[3:0] >= 4'h9 &&
				port[3:0] <= 4'he) ||
				(tgt == bad_pkg::TGT_FDC);
			// Floppy port is shared: never claimed as the data source
			st_next.claim = (tgt != bad_pkg::TGT_NONE) && (tgt != bad_pkg::TGT_FDC);
			if (cycle_write) begin
				unique case (tgt)
					bad_pkg::TGT_CFG: begin
						if (port[0] == 1'b0) begin
							st_next.cfg_index = lane_byte({wdata, wdata, wdata, wdata}, lane);
						end else begin
							unique case (st_reg.cfg_index)
								bad_pkg::CFG_ENABLE_A_OFFSET: st_next.enable_a = wdata;
								bad_pkg::CFG_ENABLE_B_OFFSET: st_next.enable_b = wdata;
								bad_pkg::CFG_SG_BASE_OFFSET: st_next.sg_base = wdata;
								default: ;
							endcase
						end
					end
					bad_pkg::TGT_FDC: st_next.fdc_bit = wdata[bad_pkg::FDC_DMA_BIT];
					bad_pkg::TGT_NMI_MASK: st_next.rtc_copy = wdata;
					default: ;
				endcase
			end else if (tgt == bad_pkg::TGT_CFG) begin
				if (port[0] == 1'b0) begin
					st_next.rdata = st_reg.cfg_index;
				end else begin
					unique case (st_reg.cfg_index)
						bad_pkg::CFG_ENABLE_A_OFFSET: st_next.rdata = st_reg.enable_a;
						bad_pkg::CFG_ENABLE_B_OFFSET: st_next.rdata = st_reg.enable_b;
						bad_pkg::CFG_SG_BASE_OFFSET: st_next.rdata = st_reg.sg_base;
						default: st_next.rdata = 8'h00;
					endcase
				end
			end
		end
		if (rst) begin
			st_next.enable_a  = bad_pkg::ENABLE_A_RESET;
			st_next.enable_b  = bad_pkg::ENABLE_B_RESET;
			st_next.sg_base   = bad_pkg::SG_BASE_RESET;
			st_next.cfg_index = 8'h00;
			st_next.fdc_bit   = 1'b0;
			st_next.rtc_copy  = 8'h00;
			st_next.cs_n      = 1'b1;
			st_next.target    = 4'h0;
			st_next.wo        = 1'b0;
			st_next.claim     = 1'b0;
			st_next.rdata     = 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		st_reg <= st_next;
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb begin
		bios_chip_select_n = st_reg.cs_n;
		io_target          = st_reg.target;
		io_write_only      = st_reg.wo;
		io_claim           = st_reg.claim;
		rdata              = st_reg.rdata;
		floppy_dma_enable  = st_reg.fdc_bit;
		rtc_index          = st_reg.rtc_copy;
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_io_no_select;
		@(posedge mclk) disable iff (rst) (cycle_valid && cycle_io) |=> bios_chip_select_n;
	endproperty
	a_io_no_select: assert property (p_io_no_select) else $error("select on io cycle");

	property p_enl_gate;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && !cycle_io && any_lane && latched_addr[31:19] == 13'h1fff &&
		latched_addr[18:17] != 2'h3) |=> (bios_chip_select_n == !$past(st_reg.enable_a[5]));
	endproperty
	a_enl_gate: assert property (p_enl_gate) else $error("enlarged gate wrong");

	property p_16m_gate;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && !cycle_io && any_lane && latched_addr[31:16] == 16'h00ff &&
		!st_reg.enable_b[2]) |=> bios_chip_select_n;
	endproperty
	a_16m_gate: assert property (p_16m_gate) else $error("16M alias without enable");

	property p_video_low;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && !cycle_io && any_lane && latched_addr[31:14] == 18'h00030)
		|=> (bios_chip_select_n == !$past(st_reg.enable_b[0]));
	endproperty
	a_video_low: assert property (p_video_low) else $error("video low alias wrong");

	property p_fdc_no_claim;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && any_lane && port == 16'h03f2) |=> !io_claim && io_write_only;
	endproperty
	a_fdc_no_claim: assert property (p_fdc_no_claim) else $error("floppy port claimed");

	property p_pic_alias;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && any_lane && port == 16'h003d) |=> io_target == 4'h2;
	endproperty
	a_pic_alias: assert property (p_pic_alias) else $error("pic alias missed");

	property p_cfg_full;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && any_lane && port == 16'h0032) |=> io_target != 4'h3;
	endproperty
	a_cfg_full: assert property (p_cfg_full) else $error("cfg port aliased");

	property p_dma1_alias;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && any_lane && port == 16'h0018) |=> io_target == 4'h1;
	endproperty
	a_dma1_alias: assert property (p_dma1_alias) else $error("dma1 alias missed");

	property p_page3_full;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && any_lane && port == 16'h0092) |=> io_target != 4'h7;
	endproperty
	a_page3_full: assert property (p_page3_full) else $error("page 3 aliased");

	property p_reset_values;
		@(posedge mclk) $past(rst) |-> (st_reg.enable_a == 8'h00 && st_reg.sg_base == 8'h04);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

	property p_high_gate;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && !cycle_io && any_lane && (latched_addr[31:16] == 16'h000f ||
		latched_addr[31:16] == 16'hffef || latched_addr[31:16] == 16'hffff))
		|=> (bios_chip_select_n == !$past(st_reg.enable_a[4]));
	endproperty
	a_high_gate: assert property (p_high_gate) else $error("high region gate wrong");

	property p_low_gate;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && !cycle_io && any_lane && (latched_addr[31:16] == 16'h000e ||
		latched_addr[31:16] == 16'hffee || latched_addr[31:16] == 16'hfffe))
		|=> (bios_chip_select_n == !$past(st_reg.enable_a[latched_addr[15:14]]));
	endproperty
	a_low_gate: assert property (p_low_gate) else $error("low region gate wrong");

	property p_video_high;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && !cycle_io && any_lane && latched_addr[31:14] == 18'h00031)
		|=> (bios_chip_select_n == !$past(st_reg.enable_b[1]));
	endproperty
	a_video_high: assert property (p_video_high) else $error("video high alias wrong");

	property p_16m_both;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && !cycle_io && any_lane && latched_addr[31:16] == 16'h00ff &&
		st_reg.enable_a[4] && st_reg.enable_b[2]) |=> !bios_chip_select_n;
	endproperty
	a_16m_both: assert property (p_16m_both) else $error("16M alias not selected");

	property p_refused;
		@(posedge mclk) disable iff (rst)
		(!cycle_valid || !any_lane) |=> bios_chip_select_n && io_target == 4'h0 && !io_claim;
	endproperty
	a_refused: assert property (p_refused) else $error("refused cycle decoded");

	property p_rtc_copy;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && cycle_write && any_lane && port == 16'h0070)
		|=> rtc_index == $past(wdata) && io_claim;
	endproperty
	a_rtc_copy: assert property (p_rtc_copy) else $error("clock index copy wrong");

	property p_fdc_bit;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && cycle_write && any_lane && port == 16'h0372)
		|=> floppy_dma_enable == $past(wdata[3]);
	endproperty
	a_fdc_bit: assert property (p_fdc_bit) else $error("floppy bit wrong");

	property p_timer_cmd;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && any_lane && port == 16'h0053) |=> io_target == 4'h4 && io_write_only;
	endproperty
	a_timer_cmd: assert property (p_timer_cmd) else $error("timer command alias wrong");

	property p_nmi_ctl;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && any_lane && port == 16'h0063) |=> io_target == 4'h5;
	endproperty
	a_nmi_ctl: assert property (p_nmi_ctl) else $error("nmi control alias wrong");

	property p_dma2_odd;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && any_lane && port == 16'h00d9) |=> io_target == 4'h8;
	endproperty
	a_dma2_odd: assert property (p_dma2_odd) else $error("dma2 odd alias missed");

	property p_status_cmd;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && any_lane && (port == 16'h0008 || port == 16'h00d0))
		|=> io_claim && !io_write_only;
	endproperty
	a_status_cmd: assert property (p_status_cmd) else $error("status port wrong");

	property p_dma1_wo;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && any_lane && port[15:4] == 12'h000 && port[3:0] >= 4'h9 &&
		port[3:0] <= 4'he) |=> io_write_only && io_target == 4'h1;
	endproperty
	a_dma1_wo: assert property (p_dma1_wo) else $error("dma1 command port wrong");

	property p_sg_window;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && any_lane && port[15:8] == st_reg.sg_base &&
		port[7:0] >= 8'h10 && port[7:0] <= 8'h3f) |=> io_target == 4'ha && io_claim;
	endproperty
	a_sg_window: assert property (p_sg_window) else $error("scatter window missed");

	property p_cfg_read;
		@(posedge mclk) disable iff (rst)
		(cycle_valid && cycle_io && !cycle_write && any_lane && port == 16'h0023 &&
		st_reg.cfg_index == 8'h42) |=> rdata == $past(st_reg.enable_a);
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("enable read wrong");
endmodule

// [hw/bad_pkg.sv]
// Package with decoder constants, register offsets and field positions
package bad_pkg;
	// ****************************************
	// Configuration register offsets and reset values
	// ****************************************
	localparam logic [7:0] CFG_ENABLE_A_OFFSET = 8'h42;
	localparam logic [7:0] CFG_ENABLE_B_OFFSET = 8'h43;
	localparam logic [7:0] ENABLE_A_RESET      = 8'h00;
	localparam logic [7:0] ENABLE_B_RESET      = 8'h00;
	localparam logic [7:0] SG_BASE_RESET       = 8'h04;
	localparam logic [7:0] CFG_SG_BASE_OFFSET  = 8'h44;

	// ****************************************
	// Field positions in enable A
	// ****************************************
	localparam int LOW_REGION1_BIT   = 0;
	localparam int HIGH_REGION_BIT   = 4;
	localparam int ENLARGED_BIT      = 5;

	// ****************************************
	// Field positions in enable B
	// ****************************************
	localparam int VIDEO_LOW_BIT     = 0;
	localparam int VIDEO_HIGH_BIT    = 1;
	localparam int SIXTEEN_MEG_BIT   = 2;

	// ****************************************
	// Memory windows, compared on address bits 31:14 (video), 31:16 (other tags) or 31:19 (enlarged)
	// ****************************************
	localparam logic [17:0] CONV_LOW_BASE   = 18'h00038;
	localparam logic [17:0] VIDEO_BASE      = 18'h00030;
	localparam logic [15:0] HIGH_CONV_TAG   = 16'h000f;
	localparam logic [15:0] HIGH_16M_TAG    = 16'h00ff;
	localparam logic [15:0] HIGH_4GM1_TAG   = 16'hffef;
	localparam logic [15:0] HIGH_4G_TAG     = 16'hffff;
	localparam logic [15:0] LOW_4GM1_TAG    = 16'hffee;
	localparam logic [15:0] LOW_4G_TAG      = 16'hfffe;
	localparam logic [12:0] ENL_TAG         = 13'h1fff;
	localparam logic [2:0]  ENL_TOP_SUB     = 3'h6;

	// ****************************************
	// I/O ports
	// ****************************************
	localparam logic [15:0] IO_CFG_INDEX = 16'h0022;
	localparam logic [15:0] IO_CFG_DATA  = 16'h0023;
	localparam logic [15:0] IO_DMA3_PAGE = 16'h0082;
	localparam logic [15:0] IO_FDC_SEC   = 16'h0372;
	localparam logic [15:0] IO_FDC_PRI   = 16'h03f2;
	localparam int          FDC_DMA_BIT  = 3;
	localparam logic [7:0]  SG_LOW_FIRST = 8'h10;
	localparam logic [7:0]  SG_LOW_LAST  = 8'h3f;

	// ****************************************
	// Target codes of the I/O decoder
	// ****************************************
	typedef enum logic [3:0] {
		TGT_NONE     = 4'h0,
		TGT_DMA1     = 4'h1,
		TGT_PIC1     = 4'h2,
		TGT_CFG      = 4'h3,
		TGT_TIMER    = 4'h4,
		TGT_NMI_CTL  = 4'h5,
		TGT_NMI_MASK = 4'h6,
		TGT_PAGE     = 4'h7,
		TGT_DMA2     = 4'h8,
		TGT_FDC      = 4'h9,
		TGT_SG       = 4'ha
	} bad_target_t;
endpackage

// [hw/bad_bios_decode.sv]
// Combinational BIOS memory region decoder
`timescale 1ns/1ps
module bad_bios_decode (
	input  wire logic [31:2] addr,
	input  wire logic [7:0]  enable_a,
	input  wire logic [7:0]  enable_b,
	output logic             hit
);
	logic [17:0] blk;
	logic [15:0] tag;
	logic [1:0]  sub;
	always_comb begin
		blk = addr[31:14];
		tag = addr[31:16];
		sub = addr[15:14];
		hit = 1'b0;
		// Conventional low regions, and their aliases below 4 GB and 4 GB minus 1 MB
		if (blk[17:2] == bad_pkg::CONV_LOW_BASE[17:2] || tag == bad_pkg::LOW_4GM1_TAG ||
			tag == bad_pkg::LOW_4G_TAG) begin
			hit = enable_a[bad_pkg::LOW_REGION1_BIT + 32'(sub)];
		end
		if (tag == bad_pkg::HIGH_CONV_TAG || tag == bad_pkg::HIGH_4GM1_TAG ||
			tag == bad_pkg::HIGH_4G_TAG) begin
			hit = enable_a[bad_pkg::HIGH_REGION_BIT];
		end
		if (tag == bad_pkg::HIGH_16M_TAG) begin
			hit = enable_a[bad_pkg::HIGH_REGION_BIT] &
				enable_b[bad_pkg::SIXTEEN_MEG_BIT];
		end
		if (blk == bad_pkg::VIDEO_BASE) begin
			hit = enable_b[bad_pkg::VIDEO_LOW_BIT];
		end
		if (blk == bad_pkg::VIDEO_BASE + 18'h1) begin
			hit = enable_b[bad_pkg::VIDEO_HIGH_BIT];
		end
		if (addr[31:19] == bad_pkg::ENL_TAG && addr[18:16] <= bad_pkg::ENL_TOP_SUB - 3'h1) begin
			hit = enable_a[bad_pkg::ENLARGED_BIT];
		end
	end
endmodule

// [hw/bad_io_decode.sv]
// Combinational I/O port decoder for the internal 8-bit registers
`timescale 1ns/1ps
module bad_io_decode (
	input  wire logic [15:0]      port,
	input  wire logic [7:0]       sg_base,
	output bad_pkg::bad_target_t  target
);
	always_comb begin
		target = bad_pkg::TGT_NONE;
		if (port[15:8] == 8'h00) begin
			if (port[7:5] == 3'h0) begin
				target = bad_pkg::TGT_DMA1;
			end else if (port == bad_pkg::IO_CFG_INDEX || port == bad_pkg::IO_CFG_DATA) begin
				target = bad_pkg::TGT_CFG;
			end else if (port[7:5] == 3'h1 && port[1] == 1'b0) begin
				target = bad_pkg::TGT_PIC1;
			end else if (port[7:5] == 3'h2 && port[2] == 1'b0) begin
				target = bad_pkg::TGT_TIMER;
			end else if (port[7:2] == 6'h18 && port[0] == 1'b1) begin
				target = bad_pkg::TGT_NMI_CTL;
			end else if (port[7:3] == 5'h0e && port[0] == 1'b0) begin
				target = bad_pkg::TGT_NMI_MASK;
			end else if (port == bad_pkg::IO_DMA3_PAGE ||
				(port[7:5] == 3'h4 && port[3:0] != 4'h2)) begin
				target = bad_pkg::TGT_PAGE;
			end else if (port[7:5] == 3'h6) begin
				target = bad_pkg::TGT_DMA2;
			end
		end
		if (port == bad_pkg::IO_FDC_SEC || port == bad_pkg::IO_FDC_PRI) begin
			target = bad_pkg::TGT_FDC;
		end
		if (port[15:8] == sg_base && port[7:0] >= bad_pkg::SG_LOW_FIRST &&
			port[7:0] <= bad_pkg::SG_LOW_LAST) begin
			target = bad_pkg::TGT_SG;
		end
	end
endmodule

// [testbench/bad_bus_master.sv]
// Bus master model that issues memory and I/O cycles to the decoder
`timescale 1ns/1ps
module bad_bus_master (
	input  wire logic        mclk,
	output logic             cycle_valid,
	output logic             cycle_io,
	output logic             cycle_write,
	output logic [31:2]      latched_addr,
	output logic [3:0]       byte_en_n,
	output logic [7:0]       wdata
);
	initial begin
		cycle_valid = 1'b0;
		cycle_io = 1'b0;
		cycle_write = 1'b0;
		latched_addr = '0;
		byte_en_n = 4'hf;
		wdata = 8'h00;
	end

	// Present one cycle and hold it across the next sampling edge
	task automatic cyc(input logic io, input logic wr, input logic [31:0] a,
		input logic [3:0] be_n, input logic [7:0] d);
		cycle_valid = 1'b1;
		cycle_io = io;
		cycle_write = wr;
		latched_addr = a[31:2];
		byte_en_n = be_n;
		wdata = d;
		@(posedge mclk);
		#1;
	endtask

	// Released address, byte enable and data lines show the inverse of their last value
	task automatic idle();
		cycle_valid = 1'b0;
		latched_addr = ~latched_addr;
		byte_en_n = ~byte_en_n;
		wdata = ~wdata;
		@(posedge mclk);
		#1;
	endtask
endmodule

// [testbench/testbench.sv]
// Self-checking testbench of the BIOS and I/O address decoder
`timescale 1ns/1ps
module testbench;
	localparam logic [31:0] PROBES [17] = '{
		32'h000c0000, 32'h000c4000, 32'h000dfffc, 32'h000e0000, 32'h000e4000, 32'h000e8000,
		32'h000ec000, 32'h000f0000, 32'h00ff0000, 32'h00fefffc, 32'hffee0000, 32'hffeec000,
		32'hffef0000, 32'hfff80000, 32'hfffdfffc, 32'hfffe4000, 32'hffff8000};
	logic        mclk;
	logic        rst;
	logic        cycle_valid;
	logic        cycle_io;
	logic        cycle_write;
	logic [31:2] latched_addr;
	logic [3:0]  byte_en_n;
	logic [7:0]  wdata;
	logic        bios_chip_select_n;
	logic [3:0]  io_target;
	logic        io_write_only;
	logic        io_claim;
	logic [7:0]  rdata;
	logic        floppy_dma_enable;
	logic [7:0]  rtc_index;
	logic [15:0] lfsr;
	logic [15:0] r;
	logic [15:0] v;
	logic [31:0] a;
	logic [7:0]  ea;
	logic [7:0]  eb;
	logic [7:0]  sgb;
	int          err_count;
	int          num_checks;
	int          i;
	int          k;

	bad_bus_master bm (.mclk(mclk), .cycle_valid(cycle_valid), .cycle_io(cycle_io),
		.cycle_write(cycle_write), .latched_addr(latched_addr), .byte_en_n(byte_en_n),
		.wdata(wdata));
	bad_decoder dut (.mclk(mclk), .rst(rst), .cycle_valid(cycle_valid), .cycle_io(cycle_io),
		.cycle_write(cycle_write), .latched_addr(latched_addr), .byte_en_n(byte_en_n),
		.wdata(wdata), .bios_chip_select_n(bios_chip_select_n), .io_target(io_target),
		.io_write_only(io_write_only), .io_claim(io_claim), .rdata(rdata),
		.floppy_dma_enable(floppy_dma_enable), .rtc_index(rtc_index));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// ****************************************
	// Expectations and compares
	// ****************************************
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	function automatic logic bios_exp(input logic [31:0] a);
		if (a[31:14] == 18'h00030) return eb[0];
		if (a[31:14] == 18'h00031) return eb[1];
		if (a[31:16] inside {16'h000e, 16'hffee, 16'hfffe}) return ea[a[15:14]];
		if (a[31:16] inside {16'h000f, 16'hffef, 16'hffff}) return ea[4];
		if (a[31:16] == 16'h00ff) return ea[4] & eb[2];
		if (a[31:19] == 13'h1fff) return ea[5];
		return 1'b0;
	endfunction

	// Result is known flag, write-only flag and target code
	function automatic logic [5:0] io_exp(input logic [15:0] p);
		if (p == 16'h0022 || p == 16'h0023) return 6'h23;
		if (p[15:5] == 11'h000) return {1'b1, p[3:0] inside {[4'h9:4'he]}, 4'h1};
		if (p[15:5] == 11'h001 && !p[1]) return 6'h22;
		if (p[15:5] == 11'h002 && !p[2]) return {1'b1, p[1:0] == 2'h3, 4'h4};
		if (p[15:2] == 14'h0018 && p[0]) return 6'h25;
		if (p[15:3] == 13'h000e && !p[0]) return 6'h36;
		if (p == 16'h0082 || (p[15:5] == 11'h004 && p[3:0] != 4'h2)) return 6'h27;
		if (p[15:5] == 11'h006) return 6'h08;
		if (p == 16'h0372 || p == 16'h03f2) return 6'h39;
		if (p[15:8] == sgb && p[7:0] inside {[8'h10:8'h3f]}) return 6'h0a;
		return 6'h20;
	endfunction

	task automatic chk_cs(input logic [31:0] a, input logic hit);
		num_checks++;
		if (bios_chip_select_n !== !hit) begin
			err_count++;
			$display("BAD %0t select wrong at %h", $time, a);
		end
	endtask

	task automatic chk_io(input logic [15:0] p);
		logic [5:0] e;
		e = io_exp(p);
		num_checks++;
		if (io_target !== e[3:0] || io_claim !== (e[3:0] != 4'h0 && e[3:0] != 4'h9) ||
			(e[5] && io_write_only !== e[4]) || bios_chip_select_n !== 1'b1) begin
			err_count++;
			$display("BAD %0t port decode wrong at %h", $time, p);
		end
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask

	// ****************************************
	// Bus cycles and sequence
	// ****************************************
	task automatic io(input logic wr, input logic [15:0] p, input logic [7:0] d);
		bm.cyc(1'b1, wr, {16'h0000, p}, ~(4'h1 << p[1:0]), d);
	endtask

	task automatic iochk(input logic [15:0] p);
		io(1'b0, p, 8'h00);
		chk_io(p);
	endtask

	task automatic mem(input logic [31:0] a, input logic [3:0] be_n);
		bm.cyc(1'b0, 1'b0, a, be_n, 8'h00);
	endtask

	task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
		io(1'b1, 16'h0022, idx);
		io(1'b1, 16'h0023, d);
	endtask

	task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
		io(1'b1, 16'h0022, idx);
		io(1'b0, 16'h0023, 8'h00);
		chk_byte(rdata, exp);
	endtask

	task automatic set_en(input logic [7:0] na, input logic [7:0] nb);
		cfg_wr(8'h42, na);
		cfg_wr(8'h43, nb);
		ea = na;
		eb = nb;
	endtask

	task automatic do_reset();
		rst = 1'b1;
		bm.idle();
		repeat (2) @(posedge mclk);
		#1;
		rst = 1'b0;
		ea = 8'h00;
		eb = 8'h00;
		sgb = 8'h04;
		chk_cs(32'h0, 1'b0);
		cfg_rd(8'h42, 8'h00);
		cfg_rd(8'h43, 8'h00);
		cfg_rd(8'h44, 8'h04);
		mem(32'hffff0000, 4'he);
		chk_cs(32'hffff0000, 1'b0);
		iochk(16'h0410);
		iochk(16'h043f);
		iochk(16'h040f);
	endtask

	task automatic finish_test();
		if (err_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		finish_test();
	end

	initial begin
		rst = 1'b1;
		#1;
		lfsr = 16'hcff5;
		err_count = 0;
		num_checks = 0;
		do_reset();
		for (k = 0; k < 18; k++) begin
			v = (k == 17) ? 16'h0410 : 16'h0001 << k;
			set_en(v[7:0], v[15:8]);
			for (i = 0; i < 17; i++) begin
				mem(PROBES[i], 4'he);
				chk_cs(PROBES[i], bios_exp(PROBES[i]));
			end
		end
		for (i = 0; i < 200; i++) begin
			if (i % 25 == 0) begin
				r = rnd();
				set_en(r[7:0], r[15:8]);
				cfg_rd(8'h42, ea);
				cfg_rd(8'h43, eb);
			end
			r = rnd();
			a = {PROBES[r % 17][31:16], rnd()};
			r = rnd();
			mem(a, (r[3:0] == 4'hf) ? 4'he : r[3:0]);
			chk_cs(a, bios_exp(a));
		end
		set_en(8'h10, 8'h00);
		repeat (3) begin
			mem(32'hffff0000, 4'h7);
			chk_cs(32'hffff0000, 1'b1);
		end
		mem(32'hffff0000, 4'hf);
		chk_cs(32'hffff0000, 1'b0);
		bm.cyc(1'b1, 1'b0, 32'h000f0000, 4'he, 8'h00);
		chk_cs(32'h000f0000, 1'b0);
		bm.idle();
		chk_cs(32'h000f0000, 1'b0);
		for (i = 0; i < 256; i++) begin
			r = rnd();
			io(r[0] && i[7:1] != 7'h11, i[15:0], r[15:8]);
			chk_io(i[15:0]);
		end
		io(1'b1, 16'h0008, 8'h00);
		chk_io(16'h0008);
		io(1'b1, 16'h00d0, 8'h00);
		chk_io(16'h00d0);
		io(1'b1, 16'h0372, 8'h08);
		chk_io(16'h0372);
		chk_byte({7'h00, floppy_dma_enable}, 8'h01);
		io(1'b1, 16'h03f2, 8'hf7);
		chk_byte({7'h00, floppy_dma_enable}, 8'h00);
		r = rnd();
		io(1'b1, 16'h0070, r[7:0]);
		chk_io(16'h0070);
		chk_byte(rtc_index, r[7:0]);
		v = rnd();
		v[7:0] = (v[7:0] == 8'h00 || v[7:0] == 8'h04) ? 8'h0c : v[7:0];
		cfg_wr(8'h44, v[7:0]);
		sgb = v[7:0];
		cfg_rd(8'h44, sgb);
		iochk(16'h0410);
		iochk({sgb, 8'h0f});
		iochk({sgb, 8'h10});
		iochk({sgb, 8'h3f});
		iochk({sgb, 8'h40});
		for (i = 0; i < 64; i++) begin
			r = rnd();
			if (r[13]) r[15:8] = sgb;
			iochk(r);
		end
		set_en(8'h3f, 8'h07);
		do_reset();
		finish_test();
	end
endmodule
